// ==== design/bmam_pkg.sv ====
// Purpose: constants for the banked memory address map
// Assumes: 13-bit program counter, 8-bit data addresses
// Notes:   none
package bmam_pkg;
    localparam int          PC_W        = 13;
    localparam int          INSN_W      = 14;
    localparam int          PROG_IMPL_W = 11;
    localparam int          DATA_W      = 8;
    localparam int          DADDR_W     = 8;
    localparam int          DIRECT_W    = 7;
    localparam int          RAM_WORDS   = 128;
    localparam int          RAM_IDX_W   = 7;
    localparam logic [12:0] RESET_VEC   = 13'h0000;
    localparam logic [12:0] INT_VEC     = 13'h0004;
    localparam logic [6:0]  SFA_TOP     = 7'h1F;
    localparam logic [6:0]  B1_RAM_LO   = 7'h20;
    localparam logic [6:0]  B1_RAM_HI   = 7'h3F;
    localparam logic [6:0]  SHARED_LO   = 7'h70;
    localparam logic [6:0]  B1_IDX_BASE = 7'h60;
    localparam logic [6:0]  B1_IDX_OFS  = 7'h40;
    typedef enum logic [1:0] {
        BMAM_SEL_NONE,
        BMAM_SEL_SFA,
        BMAM_SEL_RAM
    } bmam_sel_e;
endpackage : bmam_pkg

// ==== design/bmam_ram.sv ====
// Purpose: general purpose byte storage, flip-flops addressed by index
// Assumes: one write port, one combinational read port
// Notes:   no reset on contents; ram powers up undefined
`timescale 1ns/1ps
`default_nettype none
module bmam_ram #(
    parameter int WORDS = 128,
    parameter int IDX_W = 7,
    parameter int DW    = 8
) (
    // clock
    input  wire logic             clock,
    // write port
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [DW-1:0]    wr_data,
    // read port
    input  wire logic [IDX_W-1:0] rd_idx,
    output logic      [DW-1:0]    rd_data
);
    logic [DW-1:0] mem_reg [WORDS];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_reg[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem_reg[rd_idx];
endmodule : bmam_ram
`default_nettype wire

// ==== design/bmam_map.sv ====
// Purpose: program and data address decode with banked general ram
// Assumes: core presents pc steps and data accesses on the core clock
// Notes:   special registers live outside; this block flags them and returns their read data
//
// What this block does
// RULE_01: program counter is 13 bits, addressing 8k words of 14 bits.
// RULE_02: only program words 0000h to 07FFh are physically present.
// RULE_03: program addresses above 07FFh wrap by dropping upper bits.
// RULE_04: after reset fetch starts at program address zero.
// RULE_05: interrupt redirects fetch to program address 0004h.
// RULE_06: data memory has two banks of special and general locations.
// RULE_07: lowest 32 addresses of each bank are special registers.
// RULE_08: ram at 20h-7Fh in bank 0 and A0h-BFh in bank 1.
// RULE_09: bank 1 F0h-FFh reach the same bytes as 70h-7Fh.
// RULE_10: unimplemented data addresses read zero and keep nothing.
// RULE_11: bank select bit 0 picks bank 0, 1 picks bank 1.
// RULE_12: software keeps the reserved upper bank bits at zero.
// RULE_13: 128 bytes of ram, reached directly or via the pointer.
// RULE_14: full data address is bank select bit over 7-bit direct address.
`timescale 1ns/1ps
`default_nettype none
module bmam_map
    import bmam_pkg::*;
(
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // program counter control
    input  wire logic                          pc_step,
    input  wire logic                          pc_load,
    input  wire logic [bmam_pkg::PC_W-1:0]     pc_load_value,
    input  wire logic                          int_take,
    // program storage address
    output logic      [bmam_pkg::PC_W-1:0]     pc,
    output logic      [bmam_pkg::PROG_IMPL_W-1:0] prog_addr,
    // data access
    input  wire logic                          bank_select_bit,
    input  wire logic                          indirect_sel,
    input  wire logic [bmam_pkg::DIRECT_W-1:0] direct_addr,
    input  wire logic [bmam_pkg::DADDR_W-1:0]  indirect_pointer_register,
    input  wire logic                          data_wr,
    input  wire logic                          data_rd,
    input  wire logic [bmam_pkg::DATA_W-1:0]   data_wdata,
    output logic      [bmam_pkg::DATA_W-1:0]   data_rdata,
    // special register port
    output logic                               special_function_area_sel,
    output logic      [bmam_pkg::DADDR_W-1:0]  data_addr,
    input  wire logic [bmam_pkg::DATA_W-1:0]   special_rdata
);
    import bmam_pkg::*;

    typedef struct packed {
        logic [PC_W-1:0]   pc;
        logic [DATA_W-1:0] rdata;
    } bmam_state_s;

    bmam_state_s st_reg;
    bmam_state_s st_next;

    // classify a 7-bit in-bank offset for a given bank
    function automatic bmam_sel_e bmam_classify(input logic bank,
                                                input logic [6:0] ofs);
        if (ofs <= SFA_TOP) begin
            return BMAM_SEL_SFA;                               // RULE_07
        end else if (!bank) begin
            return BMAM_SEL_RAM;                               // RULE_08
        end else if (ofs <= B1_RAM_HI || ofs >= SHARED_LO) begin
            return BMAM_SEL_RAM;                               // RULE_08
        end else begin
            return BMAM_SEL_NONE;                              // RULE_10
        end
    endfunction : bmam_classify

    // map a banked offset to a ram index
    function automatic logic [RAM_IDX_W-1:0] bmam_ram_index(
        input logic bank, input logic [6:0] ofs);
        if (!bank) begin
            return ofs - B1_RAM_LO;
        end else if (ofs >= SHARED_LO) begin
            return ofs - B1_RAM_LO;                            // RULE_09
        end else begin
            return ofs + B1_IDX_OFS;
        end
    endfunction : bmam_ram_index

    logic [DADDR_W-1:0]   addr;
    bmam_sel_e            sel;
    logic [RAM_IDX_W-1:0] ram_idx;
    logic [DATA_W-1:0]    ram_rdata;

    // the pointer carries its own bank bit in bit 7
    assign addr = indirect_sel ? indirect_pointer_register       // RULE_13
                               : {bank_select_bit, direct_addr}; // RULE_14 RULE_11
    assign sel     = bmam_classify(addr[7], addr[6:0]);          // RULE_06
    assign ram_idx = bmam_ram_index(addr[7], addr[6:0]);

    bmam_ram #(
        .WORDS (RAM_WORDS),
        .IDX_W (RAM_IDX_W),
        .DW    (DATA_W)
    ) u_ram (
        .clock   (clock),
        .wr_en   (data_wr && sel == BMAM_SEL_RAM),               // RULE_10
        .wr_idx  (ram_idx),
        .wr_data (data_wdata),
        .rd_idx  (ram_idx),
        .rd_data (ram_rdata)
    );

    always_comb begin
        st_next = st_reg;
        if (int_take) begin
            st_next.pc = INT_VEC;                              // RULE_05
        end else if (pc_load) begin
            st_next.pc = pc_load_value;
        end else if (pc_step) begin
            st_next.pc = st_reg.pc + 13'h0001;                 // RULE_01
        end
        if (data_rd) begin
            case (sel)
                BMAM_SEL_RAM: st_next.rdata = ram_rdata;
                BMAM_SEL_SFA: st_next.rdata = special_rdata;
                default:      st_next.rdata = '0;              // RULE_10
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '{pc: RESET_VEC, rdata: '0};             // RULE_04
        end else begin
            st_reg <= st_next;
        end
    end

    assign pc         = st_reg.pc;
    // upper pc bits are ignored, so fetch wraps into the implemented words
    assign prog_addr  = st_reg.pc[PROG_IMPL_W-1:0];            // RULE_02 RULE_03
    assign data_rdata = st_reg.rdata;
    assign special_function_area_sel = (sel == BMAM_SEL_SFA);
    assign data_addr  = addr;

    property reset_vec_p;
        @(posedge clock) rst |=> (pc == RESET_VEC);
    endproperty
    reset_vector_a: assert property (reset_vec_p) // RULE_04
        else $error("pc not at reset vector after reset");

    int_vector_a: assert property (@(posedge clock) disable iff (rst) // RULE_05
        int_take |=> pc == INT_VEC)
        else $error("interrupt did not redirect to vector");

    // a loaded pc above the implemented words must fold onto its low bits
    prog_wrap_a: assert property (@(posedge clock) disable iff (rst) // RULE_03
        pc_load && !int_take |=> prog_addr == 11'($past(pc_load_value)))
        else $error("program address not wrapped");

    pc_step_a: assert property (@(posedge clock) disable iff (rst) // RULE_01
        pc_step && !pc_load && !int_take |=> pc == $past(pc) + 13'h0001)
        else $error("pc did not advance by one");

    sequence unimpl_read_s;
        data_rd && sel == BMAM_SEL_NONE;
    endsequence
    unimpl_zero_a: assert property (@(posedge clock) disable iff (rst) // RULE_10
        unimpl_read_s |=> data_rdata == 8'h00)
        else $error("unimplemented read not zero");

    sfa_low_a: assert property (@(posedge clock) disable iff (rst) // RULE_07
        special_function_area_sel == (addr[6:0] <= 7'h1F))
        else $error("special area decode wrong");

    sequence shared_wr_s;
        data_wr && !indirect_sel && bank_select_bit && direct_addr >= 7'h70;
    endsequence
    mirror_map_a: assert property (@(posedge clock) disable iff (rst) // RULE_09
        shared_wr_s ##1 (data_rd && !indirect_sel && !bank_select_bit
                         && direct_addr == $past(direct_addr) && !data_wr)
        |=> data_rdata == $past(data_wdata, 2))
        else $error("shared ram not mirrored");

    bank_addr_a: assert property (@(posedge clock) disable iff (rst) // RULE_14
        !indirect_sel |-> data_addr == {bank_select_bit, direct_addr})
        else $error("data address not formed from bank bit");

    b1_hole_a: assert property (@(posedge clock) disable iff (rst) // RULE_08
        addr >= 8'hC0 && addr < 8'hF0 |-> sel == BMAM_SEL_NONE)
        else $error("bank 1 hole decoded as ram");
endmodule : bmam_map
`default_nettype wire

// ==== sim/bmam_sfa_model.sv ====
// Purpose: special register file at the far side of the address map
// Assumes: combinational read of external special registers
// Notes:   data is a pattern of the address so a wrong mux shows
`timescale 1ns/1ps
`default_nettype none
module bmam_sfa_model (
    // address from the map
    input  wire logic [7:0] data_addr,
    // read data back
    output logic      [7:0] special_rdata
);
    // bank bit kept in the pattern: each bank has its own registers
    assign special_rdata = data_addr ^ 8'hA5;
endmodule : bmam_sfa_model
`default_nettype wire

// ==== sim/tb_bmam_map.sv ====
// Purpose: self-checking bench for the banked memory address map
// Assumes: one core clock, synchronous reset
// Notes:   ram mirrored in a shadow array; random mix of direct/indirect
`timescale 1ns/1ps
`default_nettype none
module tb_bmam_map;
    import bmam_pkg::*;
    logic clock = 0, rst = 1, pc_step = 0, pc_load = 0, int_take = 0;
    logic [12:0] pc_load_value = 0, pc;
    logic [10:0] prog_addr;
    // only one bank bit exists here; reserved upper bits stay zero
    logic bank_select_bit = 0;
    logic indirect_sel = 0, data_wr = 0, data_rd = 0, sfa;
    logic [6:0] direct_addr = 0;
    logic [7:0] indirect_pointer_register = 0, data_wdata = 0;
    logic [7:0] data_rdata, data_addr, special_rdata;
    logic [7:0] shadow [128];
    int fails = 0, samples_checked = 0;
    logic [31:0] seed = 53;

    bmam_map i_bmam_map (.clock(clock), .rst(rst), .pc_step(pc_step),
        .pc_load(pc_load), .pc_load_value(pc_load_value),
        .int_take(int_take), .pc(pc), .prog_addr(prog_addr),
        .bank_select_bit(bank_select_bit), .indirect_sel(indirect_sel),
        .direct_addr(direct_addr),
        .indirect_pointer_register(indirect_pointer_register),
        .data_wr(data_wr), .data_rd(data_rd), .data_wdata(data_wdata),
        .data_rdata(data_rdata), .special_function_area_sel(sfa),
        .data_addr(data_addr), .special_rdata(special_rdata));
    bmam_sfa_model i_bmam_sfa_model (.data_addr(data_addr),
        .special_rdata(special_rdata));

    initial begin
        forever #4 clock = ~clock;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // -2 special, -1 unimplemented, else shadow index
    function automatic int ram_idx(logic [7:0] a);
        if (a[6:0] < 7'h20) return -2;
        if (!a[7]) return int'(a) - 32;
        if (a >= 8'hF0) return int'(a) - 240 + 80;
        if (a <= 8'hBF) return int'(a) - 160 + 96;
        return -1;
    endfunction : ram_idx

    function automatic logic [7:0] exp_rd(logic [7:0] a);
        int i = ram_idx(a);
        return i == -2 ? a ^ 8'hA5 : i == -1 ? 8'h00 : shadow[i];
    endfunction : exp_rd

    task automatic chk(string what, logic [12:0] seen, logic [12:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic acc(logic wr, logic [7:0] a, logic [7:0] d);
        logic [31:0] r;
        r = xs();
        @(posedge clock);
        indirect_sel <= r[0];
        indirect_pointer_register <= r[0] ? a : r[15:8];
        bank_select_bit <= r[0] ? r[1] : a[7];
        direct_addr <= r[0] ? r[22:16] : a[6:0];
        data_wr <= wr;
        data_rd <= !wr;
        data_wdata <= d;
        #1 chk("data_addr", data_addr, a);
        chk("sfa_sel", sfa, a[6:0] < 7'h20);
        @(posedge clock);
        data_wr <= 0;
        data_rd <= 0;
        if (wr && ram_idx(a) >= 0) shadow[ram_idx(a)] = d;
        #1 if (!wr) chk("data_rdata", data_rdata, exp_rd(a));
    endtask : acc

    // op bits: interrupt, load, step
    task automatic pcop(logic [2:0] op, logic [12:0] v, logic [12:0] e);
        @(posedge clock);
        {int_take, pc_load, pc_step} <= op;
        pc_load_value <= v;
        @(posedge clock);
        {int_take, pc_load, pc_step} <= 3'h0;
        #1 chk("pc", pc, e);
        chk("prog_addr", prog_addr, e[10:0]);
    endtask : pcop

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    initial begin
        #(8 * 20000);
        fails++;
        end_of_test();
    end

    initial begin
        logic [31:0] r;
        repeat (12) @(posedge clock);
        rst <= 0;
        #1 chk("pc", pc, RESET_VEC);
        for (int a = 0; a < 256; a++) acc(1, 8'(a), 8'(xs()));
        acc(1, 8'hF5, 8'h5A);
        acc(0, 8'h75, 8'h00);
        acc(1, 8'h7A, 8'hC3);
        acc(0, 8'hFA, 8'h00);
        acc(0, 8'hC3, 8'h00);
        // back to back: bank 1 write at F6h, bank 0 read of 76h next cycle
        @(posedge clock);
        indirect_sel <= 0;
        bank_select_bit <= 1;
        direct_addr <= 7'h76;
        data_wdata <= 8'h3C;
        data_wr <= 1;
        @(posedge clock);
        bank_select_bit <= 0;
        data_wr <= 0;
        data_rd <= 1;
        @(posedge clock);
        data_rd <= 0;
        shadow[86] = 8'h3C;
        #1 chk("data_rdata", data_rdata, 8'h3C);
        for (int n = 0; n < 600; n++) begin
            r = xs();
            acc(r[8], r[7:0], r[23:16]);
        end
        pcop(3'h2, 13'h07FF, 13'h07FF);
        pcop(3'h1, 13'h0000, 13'h0800);
        pcop(3'h2, 13'h1FFF, 13'h1FFF);
        pcop(3'h1, 13'h0000, 13'h0000);
        pcop(3'h7, 13'h0123, INT_VEC);
        pcop(3'h3, 13'h0ABC, 13'h0ABC);
        for (int n = 0; n < 20; n++) begin
            r = xs();
            pcop(3'h2, r[12:0], r[12:0]);
        end
        @(posedge clock);
        rst <= 1;
        @(posedge clock);
        rst <= 0;
        #1 chk("pc", pc, RESET_VEC);
        chk("prog_addr", prog_addr, 13'h0000);
        chk("data_rdata", data_rdata, 13'h0000);
        end_of_test();
    end
endmodule : tb_bmam_map
`default_nettype wire
